// ==== hw/bpm_pwm_top.sv ====
// module: bridge, variable-frequency and three-phase output waveform logic with avalon-mm registers
//
// Overview of operation
// - forward bridge: d on, b/c off, a pwm
// - reverse bridge: c on, a/d off, b pwm
// - direction change runs falling or rising dead band
// - control mode field picks bridge direction
// - variable frequency: a toggles per period event
// - period event adds fraction setting to accumulator
// - turn-on: b off, rising dead band, a on
// - turn-off: a off, falling dead band, b on
// - rising a transition starts rising dead band
// - falling a transition starts falling dead band
// - dead-band counters advance every clock
// - three-phase: one high, one low, no dead band
// - a/c/e high side, b/d/f low side
// - steering code selects the active output pair
// - unlisted codes use lowest set steering bit
// - high-side enable modulates selected high output
// - low-side enable modulates selected low output
// - both enables clear: pair held at active
// - rising event activates, falling event deactivates
//
// Added by the designer: the Avalon-MM register port and the register addresses.
module bpm_pwm_top (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        period_event,
  input  wire logic        rise_event,
  input  wire logic        fall_event,
  output logic             period_extend,
  output logic             drive_out_a,
  output logic             drive_out_b,
  output logic             drive_out_c,
  output logic             drive_out_d,
  output logic             drive_out_e,
  output logic             drive_out_f
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_RISE = 3'b010,
    PH_FALL = 3'b100
  } bpm_phase_type;

  typedef struct packed {
    logic          waitreq;
    logic [31:0]   rdata;
    logic [2:0]    mode;
    logic          dbr_en;
    logic          dbf_en;
    logic [5:0]    steer;
    logic          hs_en;
    logic          ls_en;
    logic [3:0]    ffa;
    logic [7:0]    dbr;
    logic [7:0]    dbf;
    logic [5:0]    outs;
    logic          level;
    logic          prim;
    logic [3:0]    acc;
    logic          extend;
    logic          last_rev;
    logic [1:0]    db_start;
    bpm_phase_type phase;
  } bpm_state_type;

  bpm_state_type s;
  bpm_state_type next_s;

  bpm_db_if db ();

  bpm_dead_band u_dead_band (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .db       (db)
  );

  assign db.start    = s.db_start;
  assign db.len_rise = s.dbr;
  assign db.len_fall = s.dbf;

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign period_extend   = s.extend;
  assign drive_out_a     = s.outs[0];
  assign drive_out_b     = s.outs[1];
  assign drive_out_c     = s.outs[2];
  assign drive_out_d     = s.outs[3];
  assign drive_out_e     = s.outs[4];
  assign drive_out_f     = s.outs[5];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offs);
    hit = (addr == offs);
  endfunction

  // steering decode: lowest set bit wins, so every nonzero code maps to one pair
  function automatic logic [5:0] steer_pair(input logic [5:0] code);
    logic [5:0] pair;
    pair = bpm_pkg::OUT_NONE;
    if (code[0]) begin
      pair = bpm_pkg::OUT_A | bpm_pkg::OUT_D;
    end else if (code[1]) begin
      pair = bpm_pkg::OUT_A | bpm_pkg::OUT_F;
    end else if (code[2]) begin
      pair = bpm_pkg::OUT_C | bpm_pkg::OUT_F;
    end else if (code[3]) begin
      pair = bpm_pkg::OUT_C | bpm_pkg::OUT_B;
    end else if (code[4]) begin
      pair = bpm_pkg::OUT_E | bpm_pkg::OUT_B;
    end else if (code[5]) begin
      pair = bpm_pkg::OUT_E | bpm_pkg::OUT_D;
    end
    return pair;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       req;
  logic       wr_ok;
  logic [4:0] sum;
  logic       is_rev;
  logic [5:0] sel;
  logic [5:0] mod;

  always_comb begin
    next_s          = s;
    next_s.db_start = '0;
    req             = avs_read || avs_write;
    wr_ok           = avs_write && !s.waitreq && avs_byteenable[0];
    sum             = {1'b0, s.acc} + {1'b0, s.ffa};
    is_rev          = (s.mode == bpm_pkg::MODE_REV);
    sel             = steer_pair(s.steer);
    mod             = (s.hs_en ? bpm_pkg::HS_MASK : bpm_pkg::OUT_NONE)
                    | (s.ls_en ? bpm_pkg::LS_MASK : bpm_pkg::OUT_NONE);

    // bus: one wait cycle, answer on the second edge of the request
    next_s.waitreq = !(req && s.waitreq);
    if (req && s.waitreq) begin
      next_s.rdata = '0;
      if (avs_read) begin
        if (hit(avs_address, bpm_pkg::ADDR_CTRL)) begin
          next_s.rdata[bpm_pkg::CTRL_MODE_LSB +: bpm_pkg::CTRL_MODE_W] = s.mode;
          next_s.rdata[bpm_pkg::CTRL_DBR_EN] = s.dbr_en;
          next_s.rdata[bpm_pkg::CTRL_DBF_EN] = s.dbf_en;
        end else if (hit(avs_address, bpm_pkg::ADDR_STEER0)) begin
          next_s.rdata[bpm_pkg::STEER_W-1:0] = s.steer;
        end else if (hit(avs_address, bpm_pkg::ADDR_STEER1)) begin
          next_s.rdata[bpm_pkg::STEER1_HS_EN] = s.hs_en;
          next_s.rdata[bpm_pkg::STEER1_LS_EN] = s.ls_en;
        end else if (hit(avs_address, bpm_pkg::ADDR_FFA)) begin
          next_s.rdata[bpm_pkg::FFA_W-1:0] = s.ffa;
        end else if (hit(avs_address, bpm_pkg::ADDR_DBR)) begin
          next_s.rdata[bpm_pkg::DB_W-1:0] = s.dbr;
        end else if (hit(avs_address, bpm_pkg::ADDR_DBF)) begin
          next_s.rdata[bpm_pkg::DB_W-1:0] = s.dbf;
        end else if (hit(avs_address, bpm_pkg::ADDR_STATUS)) begin
          next_s.rdata[bpm_pkg::STAT_OUT_LSB +: 6] = s.outs;
          next_s.rdata[bpm_pkg::STAT_ACC_LSB +: bpm_pkg::FFA_W] = s.acc;
          next_s.rdata[bpm_pkg::STAT_EXT_BIT] = s.extend;
          next_s.rdata[bpm_pkg::STAT_BUSY_BIT] = db.busy;
        end
      end
    end
    if (wr_ok) begin
      if (hit(avs_address, bpm_pkg::ADDR_CTRL)) begin
        next_s.mode   = avs_writedata[bpm_pkg::CTRL_MODE_LSB +: bpm_pkg::CTRL_MODE_W];
        next_s.dbr_en = avs_writedata[bpm_pkg::CTRL_DBR_EN];
        next_s.dbf_en = avs_writedata[bpm_pkg::CTRL_DBF_EN];
      end else if (hit(avs_address, bpm_pkg::ADDR_STEER0)) begin
        next_s.steer = avs_writedata[bpm_pkg::STEER_W-1:0];
      end else if (hit(avs_address, bpm_pkg::ADDR_STEER1)) begin
        next_s.hs_en = avs_writedata[bpm_pkg::STEER1_HS_EN];
        next_s.ls_en = avs_writedata[bpm_pkg::STEER1_LS_EN];
      end else if (hit(avs_address, bpm_pkg::ADDR_FFA)) begin
        next_s.ffa = avs_writedata[bpm_pkg::FFA_W-1:0];
      end else if (hit(avs_address, bpm_pkg::ADDR_DBR)) begin
        next_s.dbr = avs_writedata[bpm_pkg::DB_W-1:0];
      end else if (hit(avs_address, bpm_pkg::ADDR_DBF)) begin
        next_s.dbf = avs_writedata[bpm_pkg::DB_W-1:0];
      end
    end

    // shared edge-event level; a falling event in the same cycle wins
    if (rise_event) begin
      next_s.level = 1'b1;
    end
    if (fall_event) begin
      next_s.level = 1'b0;
    end

    unique case (s.mode)
      bpm_pkg::MODE_FWD, bpm_pkg::MODE_REV: begin
        next_s.extend = 1'b0;
        if (is_rev != s.last_rev) begin
          // everything off while the direction switches
          next_s.last_rev = is_rev;
          next_s.outs     = bpm_pkg::OUT_NONE;
          if (is_rev && s.dbf_en) begin
            next_s.db_start[bpm_pkg::DB_FALL] = 1'b1;
            next_s.phase = PH_FALL;
          end else if (!is_rev && s.dbr_en) begin
            next_s.db_start[bpm_pkg::DB_RISE] = 1'b1;
            next_s.phase = PH_RISE;
          end else begin
            next_s.phase = PH_IDLE;
          end
        end else if (s.phase != PH_IDLE && !(|db.done)) begin
          next_s.outs = bpm_pkg::OUT_NONE;
        end else begin
          next_s.phase = PH_IDLE;
          if (is_rev) begin
            next_s.outs = bpm_pkg::OUT_C | (next_s.level ? bpm_pkg::OUT_B : bpm_pkg::OUT_NONE);
          end else begin
            next_s.outs = bpm_pkg::OUT_D | (next_s.level ? bpm_pkg::OUT_A : bpm_pkg::OUT_NONE);
          end
        end
      end
      bpm_pkg::MODE_VF: begin
        next_s.phase = PH_IDLE;
        if (period_event) begin
          next_s.prim   = !s.prim;
          next_s.acc    = sum[3:0];
          next_s.extend = sum[4];
        end
        next_s.outs = next_s.prim ? bpm_pkg::OUT_A : bpm_pkg::OUT_NONE;
      end
      bpm_pkg::MODE_VFC: begin
        if (period_event) begin
          next_s.acc    = sum[3:0];
          next_s.extend = sum[4];
          next_s.prim   = !s.prim;
          if (!s.prim) begin
            if (s.dbr_en) begin
              next_s.outs = bpm_pkg::OUT_NONE;
              next_s.db_start[bpm_pkg::DB_RISE] = 1'b1;
              next_s.phase = PH_RISE;
            end else begin
              next_s.outs  = bpm_pkg::OUT_A;
              next_s.phase = PH_IDLE;
            end
          end else begin
            if (s.dbf_en) begin
              next_s.outs = bpm_pkg::OUT_NONE;
              next_s.db_start[bpm_pkg::DB_FALL] = 1'b1;
              next_s.phase = PH_FALL;
            end else begin
              next_s.outs  = bpm_pkg::OUT_B;
              next_s.phase = PH_IDLE;
            end
          end
        end else if (s.phase == PH_RISE && db.done[bpm_pkg::DB_RISE]) begin
          next_s.outs  = bpm_pkg::OUT_A;
          next_s.phase = PH_IDLE;
        end else if (s.phase == PH_FALL && db.done[bpm_pkg::DB_FALL]) begin
          next_s.outs  = bpm_pkg::OUT_B;
          next_s.phase = PH_IDLE;
        end else if (s.phase == PH_IDLE) begin
          next_s.outs = s.prim ? bpm_pkg::OUT_A : bpm_pkg::OUT_B;
        end
      end
      bpm_pkg::MODE_TRI: begin
        // no dead band here; unmodulated sides sit at their rising-event state
        next_s.phase  = PH_IDLE;
        next_s.extend = 1'b0;
        next_s.outs   = sel & (~mod | {6{next_s.level}});
      end
      default: begin
        next_s.phase  = PH_IDLE;
        next_s.extend = 1'b0;
        next_s.outs   = bpm_pkg::OUT_NONE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s         <= '0;
      s.waitreq <= 1'b1;
      s.phase   <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

endmodule // bpm_pwm_top

// ==== include/bpm_pkg.sv ====
// package: register map, mode codes, field layout and masks for the bridge/three-phase pwm block
package bpm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_STEER0 = 5'h04;
  localparam logic [4:0] ADDR_STEER1 = 5'h08;
  localparam logic [4:0] ADDR_FFA    = 5'h0c;
  localparam logic [4:0] ADDR_DBR    = 5'h10;
  localparam logic [4:0] ADDR_DBF    = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_W     = 3;
  localparam int CTRL_DBR_EN     = 3;
  localparam int CTRL_DBF_EN     = 4;
  localparam int STEER1_HS_EN    = 0;
  localparam int STEER1_LS_EN    = 1;
  localparam int STEER_W         = 6;
  localparam int FFA_W           = 4;
  localparam int DB_W            = 8;
  localparam int STAT_OUT_LSB    = 0;
  localparam int STAT_ACC_LSB    = 6;
  localparam int STAT_EXT_BIT    = 10;
  localparam int STAT_BUSY_BIT   = 11;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_FWD = 3'h1;
  localparam logic [2:0] MODE_REV = 3'h2;
  localparam logic [2:0] MODE_VF  = 3'h3;
  localparam logic [2:0] MODE_VFC = 3'h4;
  localparam logic [2:0] MODE_TRI = 3'h5;

  // ----------------------------------------------------------------
  // output bit order {f,e,d,c,b,a}; high side a,c,e, low side b,d,f
  // ----------------------------------------------------------------
  localparam logic [5:0] HS_MASK  = 6'h15;
  localparam logic [5:0] LS_MASK  = 6'h2a;
  localparam logic [5:0] OUT_NONE = 6'h00;
  localparam logic [5:0] OUT_A    = 6'h01;
  localparam logic [5:0] OUT_B    = 6'h02;
  localparam logic [5:0] OUT_C    = 6'h04;
  localparam logic [5:0] OUT_D    = 6'h08;
  localparam logic [5:0] OUT_E    = 6'h10;
  localparam logic [5:0] OUT_F    = 6'h20;

  // dead-band channel indices
  localparam int DB_RISE = 0;
  localparam int DB_FALL = 1;

endpackage

// ==== include/bpm_db_if.sv ====
// interface: start, length and completion signals between waveform logic and dead-band counters
interface bpm_db_if;
  logic [1:0]       start;
  logic [7:0]       len_rise;
  logic [7:0]       len_fall;
  logic [1:0]       done;
  logic             busy;

  modport ctrl (output start, output len_rise, output len_fall, input done, input busy);
  modport unit (input start, input len_rise, input len_fall, output done, output busy);
endinterface

// ==== hw/bpm_dead_band.sv ====
// module: rising and falling dead-band counters; a start on either one ends the other
module bpm_dead_band (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  bpm_db_if.unit    db
);

  typedef struct packed {
    logic [1:0][7:0] cnt;
    logic [1:0]      run;
    logic [1:0]      done;
  } bpm_db_state_type;

  bpm_db_state_type s;
  bpm_db_state_type next_s;

  logic [1:0][7:0] len;

  assign len[bpm_pkg::DB_RISE] = db.len_rise;
  assign len[bpm_pkg::DB_FALL] = db.len_fall;
  assign db.done = s.done;
  assign db.busy = |s.run;

  always_comb begin
    next_s      = s;
    next_s.done = '0;
    for (int i = 0; i < 2; i++) begin
      if (db.start[i]) begin
        // a start restarts its own count and ends the other one
        next_s.cnt[i] = '0;
        next_s.run[i] = 1'b1;
        next_s.run[1 - i] = 1'b0;
      end else if (s.run[i] && !db.start[1 - i]) begin
        if (s.cnt[i] == len[i]) begin
          next_s.run[i]  = 1'b0;
          next_s.done[i] = 1'b1;
        end else begin
          next_s.cnt[i] = s.cnt[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // bpm_dead_band

// ==== sim/bpm_pwm_chk.sv ====
// checker: port-level assertions for the bridge/three-phase pwm block
module bpm_pwm_chk (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        period_event,
  input wire logic        rise_event,
  input wire logic        fall_event,
  input wire logic        period_extend,
  input wire logic        drive_out_a,
  input wire logic        drive_out_b,
  input wire logic        drive_out_c,
  input wire logic        drive_out_d,
  input wire logic        drive_out_e,
  input wire logic        drive_out_f
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // register shadow; settle gates checks until dead bands can finish
  // ----------------------------------------------------------------
  localparam logic [5:0] PT [0:5] = '{6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};
  logic [2:0] mode;
  logic [5:0] st0;
  logic [1:0] st1;
  logic [8:0] settle;
  logic [5:0] outs;
  logic [5:0] pair;
  logic       wen;
  logic       q;
  logic       qt;
  assign outs = {drive_out_f, drive_out_e, drive_out_d, drive_out_c, drive_out_b, drive_out_a};
  assign wen  = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign q    = settle > 9'd270;
  // outputs follow a write one edge later, so only the write's own edge and the next are skipped
  assign qt   = settle > 9'd0 && mode == bpm_pkg::MODE_TRI && !wen;
  always_comb begin
    pair = 6'h00;
    for (int i = 5; i >= 0; i--)
      if (st0[i]) pair = PT[i];
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode   <= 3'h0;
      st0    <= 6'h00;
      st1    <= 2'h0;
      settle <= 9'h000;
    end else if (wen) begin
      settle <= 9'h000;
      if (avs_address == bpm_pkg::ADDR_CTRL) mode <= avs_writedata[2:0];
      if (avs_address == bpm_pkg::ADDR_STEER0) st0 <= avs_writedata[5:0];
      if (avs_address == bpm_pkg::ADDR_STEER1) st1 <= avs_writedata[1:0];
    end else if (!(&settle)) begin
      settle <= settle + 9'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_BUS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  AST_FWD_LVL: assert property (q && mode == bpm_pkg::MODE_FWD |-> drive_out_d && !drive_out_b && !drive_out_c)
    else $error("forward static levels wrong");
  AST_FWD_EV: assert property (q && mode == bpm_pkg::MODE_FWD && (rise_event || fall_event)
    |=> drive_out_a == !$past(fall_event)) else $error("forward a not following events");
  AST_REV_LVL: assert property (q && mode == bpm_pkg::MODE_REV |-> drive_out_c && !drive_out_a && !drive_out_d)
    else $error("reverse static levels wrong");
  AST_REV_EV: assert property (q && mode == bpm_pkg::MODE_REV && (rise_event || fall_event)
    |=> drive_out_b == !$past(fall_event)) else $error("reverse b not following events");
  AST_VF: assert property (q && mode == bpm_pkg::MODE_VF
    |=> drive_out_a == ($past(drive_out_a) ^ $past(period_event)) && outs[5:1] == 5'h00)
    else $error("variable frequency output wrong");
  AST_VFC_ON: assert property (q && mode == bpm_pkg::MODE_VFC && period_event && !drive_out_a && drive_out_b
    |=> !drive_out_b) else $error("complementary not released first");
  AST_VFC_OFF: assert property (q && mode == bpm_pkg::MODE_VFC && period_event && drive_out_a && !drive_out_b
    |=> !drive_out_a) else $error("primary not released first");
  AST_TRI_HOLD: assert property (qt && st1 == 2'h0 |-> outs == pair)
    else $error("held steering pair wrong");
  AST_TRI_FALL: assert property (qt && st1 != 2'h0 && fall_event |=> outs == (pair
    & ~((st1[0] ? bpm_pkg::HS_MASK : 6'h00) | (st1[1] ? bpm_pkg::LS_MASK : 6'h00)))) else $error("modulation off");
  AST_TRI_RISE: assert property (qt && st1 != 2'h0 && rise_event && !fall_event |=> outs == pair)
    else $error("rising event pair wrong");
  AST_TRI_CNT: assert property (qt |-> $countones(outs & bpm_pkg::HS_MASK) <= 1
    && $countones(outs & bpm_pkg::LS_MASK) <= 1) else $error("more than one drive per side");
endmodule // bpm_pwm_chk

bind bpm_pwm_top bpm_pwm_chk i_chk (.*);

// ==== sim/bpm_gate_model.sv ====
// partner: gate-driver model that latches any half-bridge shoot-through
module bpm_gate_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [5:0] gate,
  output logic            shoot
);
  timeunit 1ns;
  timeprecision 1ns;
  // high and low switch of one leg together would short the rail
  always @(posedge core_clk) begin
    if (sys_rst) shoot <= 1'b0;
    else if (|(gate & (gate >> 1) & 6'h15)) shoot <= 1'b1;
  end
endmodule // bpm_gate_model

// ==== sim/testbench.sv ====
// testbench: self-checking bench for the bridge/three-phase pwm block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        period_event = 1'b0;
  logic        rise_event = 1'b0;
  logic        fall_event = 1'b0;
  logic        period_extend;
  wire  [5:0]  outs;
  logic        shoot;
  logic [31:0] rd_data;
  logic [31:0] seed = 32'h26c99bee;
  int          failures = 0;
  int          compares = 0;
  int          acc, ffa, ext, cnt, prev, dr, df;
  logic [5:0]  codes [0:9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h0c, 6'h30, 6'h3f};
  logic [5:0]  exps [0:9] = '{6'h00, 6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18, 6'h24, 6'h12, 6'h09};
  always #20 core_clk = ~core_clk;
  bpm_pwm_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .period_event(period_event),
    .rise_event(rise_event), .fall_event(fall_event), .period_extend(period_extend),
    .drive_out_a(outs[0]), .drive_out_b(outs[1]), .drive_out_c(outs[2]), .drive_out_d(outs[3]),
    .drive_out_e(outs[4]), .drive_out_f(outs[5]));
  bpm_gate_model i_gate (.core_clk(core_clk), .sys_rst(sys_rst), .gate(outs), .shoot(shoot));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd_data = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ev(input logic [2:0] e);
    {period_event, rise_event, fall_event} <= e;
    @(posedge core_clk);
    {period_event, rise_event, fall_event} <= 3'b000;
    @(posedge core_clk);
  endtask
  task automatic wait_out(input int i);
    cnt = 0;
    while (outs[i] !== 1'b1 && cnt < 600) begin
      @(posedge core_clk);
      cnt++;
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk(outs, 0);
    chk(avs_waitrequest, 1);
    bus(1'b0, 5'h1c, 0);
    chk(rd_data, 0);
    seed = xs(seed);
    ffa = seed[3:0] | 1;
    bus(1'b1, bpm_pkg::ADDR_FFA, ffa);
    bus(1'b1, bpm_pkg::ADDR_CTRL, bpm_pkg::MODE_VF);
    {acc, prev, ext} = 0;
    repeat (280) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      ev(i[0] ? 3'b011 : 3'b100);
      if (!i[0]) begin
        prev ^= 1;
        acc += ffa;
        ext = acc > 15;
        acc &= 15;
      end
      chk(outs, prev);
      chk(period_extend, ext);
    end
    bus(1'b0, bpm_pkg::ADDR_STATUS, 0);
    chk(rd_data[11:0], (ext << 10) | (acc << 6) | prev);
    seed = xs(seed);
    dr = seed[2:0];
    df = seed[6:4];
    bus(1'b1, bpm_pkg::ADDR_DBR, dr);
    bus(1'b1, bpm_pkg::ADDR_DBF, df);
    bus(1'b1, bpm_pkg::ADDR_CTRL, 32'h1c);
    repeat (280) @(posedge core_clk);
    for (int i = 0; i < 3; i++) begin
      prev = outs[0];
      ev(3'b100);
      wait_out(prev);
      chk(cnt, prev ? df + 3 : dr + 3);
      chk(outs, prev ? 2 : 1);
    end
    bus(1'b1, bpm_pkg::ADDR_DBR, 12);
    bus(1'b1, bpm_pkg::ADDR_DBF, 40);
    bus(1'b1, bpm_pkg::ADDR_CTRL, 32'h19);
    repeat (280) @(posedge core_clk);
    chk(outs, 6'h08);
    ev(3'b010);
    chk(outs, 6'h09);
    ev(3'b011);
    chk(outs, 6'h08);
    bus(1'b1, bpm_pkg::ADDR_CTRL, 32'h1a);
    wait_out(2);
    chk(cnt >= 40 && cnt <= 46, 1);
    repeat (280) @(posedge core_clk);
    chk(outs, 6'h04);
    ev(3'b010);
    chk(outs, 6'h06);
    ev(3'b001);
    chk(outs, 6'h04);
    bus(1'b1, bpm_pkg::ADDR_CTRL, 32'h19);
    wait_out(3);
    chk(cnt >= 12 && cnt <= 18, 1);
    bus(1'b1, bpm_pkg::ADDR_CTRL, bpm_pkg::MODE_TRI);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, bpm_pkg::ADDR_STEER1, 0);
      bus(1'b1, bpm_pkg::ADDR_STEER0, codes[i]);
      @(posedge core_clk);
      chk(outs, exps[i]);
      for (int k = 1; k < 4; k++) begin
        bus(1'b1, bpm_pkg::ADDR_STEER1, k);
        ev(3'b001);
        chk(outs, exps[i] & ~((k[0] ? bpm_pkg::HS_MASK : 0) | (k[1] ? bpm_pkg::LS_MASK : 0)));
        ev(3'b010);
        chk(outs, exps[i]);
      end
    end
    bus(1'b1, bpm_pkg::ADDR_STEER1, 0);
    avs_byteenable <= 4'he;
    bus(1'b1, bpm_pkg::ADDR_STEER0, 32'h20);
    avs_byteenable <= 4'hf;
    @(posedge core_clk);
    chk(outs, 6'h09);
    chk(shoot, 0);
    give_verdict;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    give_verdict;
  end
endmodule // testbench
